// ### fifo_out_pkg.sv
// Package: constants, types and register map of the FIFO output stage
package fifo_out_pkg;

  localparam int DATA_W  = 8;
  localparam int DEPTH   = 8;
  localparam int HADDR_W = 32;
  localparam int HDATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFFS_CTRL   = 8'h00;
  localparam logic [7:0] OFFS_PUSH   = 8'h04;
  localparam logic [7:0] OFFS_STATUS = 8'h08;
  localparam logic [7:0] OFFS_HOLD   = 8'h0C;

  // Field positions
  localparam int CTRL_MODE_BIT   = 0;
  localparam int ST_LAST_VALID   = 0;
  localparam int ST_OUT_REQ      = 1;
  localparam int ST_ADVANCE      = 2;
  localparam int ST_DATA_AVAIL   = 3;
  localparam int ST_IN_READY     = 4;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic {
    MODE_EDGE,
    MODE_SYNC
  } mode_e;

  typedef struct packed {
    logic              valid;
    logic [DATA_W-1:0] data;
  } entry_s;

  typedef struct packed {
    logic [HADDR_W-1:0] haddr;
    logic [1:0]         htrans;
    logic               hwrite;
    logic [2:0]         hsize;
    logic               hsel;
    logic               hready;
  } ahb_req_s;

endpackage

// ### shift_fifo_core.sv
// Register-based shift FIFO with per-column valid bits
`timescale 1ns/1ps
module shift_fifo_core
  import fifo_out_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire fifo_out_pkg::entry_s pushIn,
  input  wire logic                advance,
  output logic                     inReady,
  output fifo_out_pkg::entry_s     lastEntry
);

  entry_s column [DEPTH];
  logic   shiftEn [DEPTH+1];

  // Advance is an extra active-low valid bit past the last column
  assign shiftEn[DEPTH] = advance;
  assign inReady        = shiftEn[0];
  assign lastEntry      = column[DEPTH-1];

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < DEPTH; i++) begin : g_col
    entry_s feed;
    // Ripple OR: shift if own or any downstream valid bit is low
    assign shiftEn[i] = !column[i].valid || shiftEn[i+1];
    if (i == 0) begin : g_first
      assign feed = pushIn;
    end else begin : g_rest
      assign feed = column[i-1];
    end
    always_ff @(posedge clk) begin
      if (reset) begin
        column[i] <= '0;
      end else if (ce && shiftEn[i]) begin
        // Invalid words are dropped; last column keeps shifting till valid
        column[i] <= feed;
      end
    end
  end

endmodule // shift_fifo_core

// ### fifo_async_output_stage.sv
// FIFO asynchronous output stage with AHB-Lite register access
//
// The placing of the registers and register access over AHB-Lite were decided locally.
`timescale 1ns/1ps
module fifo_async_output_stage
  import fifo_out_pkg::*;
(
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  input  wire logic                          hsel,
  input  wire logic [fifo_out_pkg::HADDR_W-1:0] haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic                          hready,
  input  wire logic [fifo_out_pkg::HDATA_W-1:0] hwdata,
  output logic      [fifo_out_pkg::HDATA_W-1:0] hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  input  wire logic                          readerClk,
  input  wire logic                          readerStrobe,
  output logic      [fifo_out_pkg::DATA_W-1:0] readerData,
  output logic                               dataAvail
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus side state
  ahb_req_s              req;
  logic                  dataPhase;
  logic [7:0]            phaseAddr;
  logic                  phaseWrite;
  mode_e                 mode;
  entry_s                pushIn;

  // Link side state
  logic [1:0]            clkSync;
  logic [1:0]            strobeSync;
  logic                  clkPrev;
  logic                  strobePrev;
  logic                  outReq;
  logic                  advance;
  logic                  advanceShifted;

  // FIFO
  logic                  inReady;
  entry_s                lastEntry;
  logic                  fifoAdvance;

  ////////////////////////////////////////////////////////////////////////////
  // Decode
  logic                  addrTaken;
  logic                  selCtrl;
  logic                  selPush;
  logic                  selStatus;
  logic                  selHold;
  logic [HDATA_W-1:0]    readMux;
  logic [HDATA_W-1:0]    statusWord;
  logic                  writeCtrl;
  logic                  writePush;

  assign req = '{haddr: haddr, htrans: htrans, hwrite: hwrite,
                 hsize: hsize, hsel: hsel, hready: hready};

  assign addrTaken = req.hsel && req.hready && hreadyout &&
                     req.htrans == HTRANS_NONSEQ;
  assign selCtrl   = phaseAddr == OFFS_CTRL;
  assign selPush   = phaseAddr == OFFS_PUSH;
  assign selStatus = phaseAddr == OFFS_STATUS;
  assign selHold   = phaseAddr == OFFS_HOLD;
  assign writeCtrl = dataPhase && phaseWrite && selCtrl;
  assign writePush = dataPhase && phaseWrite && selPush;

  always_comb begin
    statusWord                = '0;
    statusWord[ST_LAST_VALID] = lastEntry.valid;
    statusWord[ST_OUT_REQ]    = outReq;
    statusWord[ST_ADVANCE]    = advance;
    statusWord[ST_DATA_AVAIL] = dataAvail;
    statusWord[ST_IN_READY]   = inReady;
  end

  // Unmapped addresses read as zero, still OKAY
  assign readMux =
    selCtrl   ? {{(HDATA_W-1){1'b0}}, mode == MODE_SYNC} :
    selStatus ? statusWord :
    selHold   ? {{(HDATA_W-DATA_W){1'b0}}, readerData} :
                '0;

  ////////////////////////////////////////////////////////////////////////////
  // Link decode
  logic                  clkRise;
  logic                  clkFall;
  logic                  strobeRise;
  logic                  readyInt;
  logic                  edgeAccept;
  logic                  syncAccept;
  logic                  accept;

  assign clkRise    = clkSync[1] && !clkPrev;
  assign clkFall    = !clkSync[1] && clkPrev;
  assign strobeRise = strobeSync[1] && !strobePrev;

  // Ready only while the last word is valid and no pop is in flight
  assign readyInt   = lastEntry.valid && !outReq && !advance;

  // Strobes seen while not ready are ignored
  assign edgeAccept = mode == MODE_EDGE && strobeRise && readyInt;
  assign syncAccept = mode == MODE_SYNC && clkRise && strobeSync[1] &&
                      dataAvail && readyInt;
  assign accept     = edgeAccept || syncAccept;

  // First advance cycle pops; later cycles only let the FIFO refill
  assign fifoAdvance = advance && !advanceShifted;

  ////////////////////////////////////////////////////////////////////////////
  // Bus address and data phase; one wait state so reads see settled state
  always_ff @(posedge clk) begin
    if (reset) begin
      dataPhase  <= 1'b0;
      phaseAddr  <= '0;
      phaseWrite <= 1'b0;
      hreadyout  <= 1'b1;
      hrdata     <= '0;
      hresp      <= HRESP_OKAY;
    end else if (ce) begin
      dataPhase <= addrTaken;
      if (addrTaken) begin
        phaseAddr  <= req.haddr[7:0];
        phaseWrite <= req.hwrite;
        hreadyout  <= 1'b0;
      end else if (dataPhase) begin
        hreadyout <= 1'b1;
        hrdata    <= phaseWrite ? '0 : readMux;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register and push path
  always_ff @(posedge clk) begin
    if (reset) begin
      mode   <= MODE_EDGE;
      pushIn <= '0;
    end else if (ce) begin
      if (writeCtrl) begin
        mode <= hwdata[CTRL_MODE_BIT] ? MODE_SYNC : MODE_EDGE;
      end
      // Push is dropped if no column is free and the FIFO is not popping
      if (writePush) begin
        pushIn <= '{valid: inReady, data: hwdata[DATA_W-1:0]};
      end else begin
        pushIn <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reader pins cross into clk; nothing reads the first stage but the second
  always_ff @(posedge clk) begin
    if (reset) begin
      clkSync    <= '0;
      strobeSync <= '0;
      clkPrev    <= 1'b0;
      strobePrev <= 1'b0;
    end else if (ce) begin
      clkSync    <= {clkSync[0], readerClk};
      strobeSync <= {strobeSync[0], readerStrobe};
      clkPrev    <= clkSync[1];
      strobePrev <= strobeSync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Holding register
  always_ff @(posedge clk) begin
    if (reset) begin
      readerData <= '0;
    end else if (ce && accept) begin
      readerData <= lastEntry.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output request and advance handshake
  always_ff @(posedge clk) begin
    if (reset) begin
      outReq         <= 1'b0;
      advance        <= 1'b0;
      advanceShifted <= 1'b0;
    end else if (ce) begin
      // Held regardless of strobe level until taken here
      outReq <= accept || (outReq && !(outReq && !advance));
      if (outReq) begin
        advance        <= 1'b1;
        advanceShifted <= 1'b0;
      end else if (advance && !advanceShifted) begin
        advanceShifted <= 1'b1;
      end else if (advance && lastEntry.valid) begin
        advance        <= 1'b0;
        advanceShifted <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Data-available toward the reader
  always_ff @(posedge clk) begin
    if (reset) begin
      dataAvail <= 1'b0;
    end else if (ce) begin
      if (mode == MODE_EDGE) begin
        dataAvail <= readyInt && !accept;
      end else if (accept) begin
        dataAvail <= 1'b0;
      end else if (clkFall) begin
        // Accept clears it; falling edge raises it again between back-to-back reads
        dataAvail <= readyInt;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  shift_fifo_core u_core (
    .clk       (clk),
    .reset     (reset),
    .ce        (ce),
    .pushIn    (pushIn),
    .advance   (fifoAdvance),
    .inReady   (inReady),
    .lastEntry (lastEntry)
  );

endmodule // fifo_async_output_stage

// ### reader_model.sv
// Reader on its own free-running clock that pulls words from the stage
`timescale 1ns/1ps
module reader_model (
  input  wire logic want,
  input  wire logic oneShot,
  input  wire logic dataAvail,
  output logic      readerClk,
  output logic      readerStrobe
);
  initial begin
    readerClk = 1'h0;
    readerStrobe = 1'h0;
    #3.3;
    forever #32 readerClk = ~readerClk;
  end
  // Edge mode needs a low gap between strobes or no new edge is seen
  always @(posedge readerClk) begin
    readerStrobe <= want && dataAvail && !(oneShot && readerStrobe);
  end
endmodule // reader_model

// ### fifo_async_output_stage_checker.sv
// Port checker for the FIFO output stage
`timescale 1ns/1ps
module fifo_async_output_stage_checker
  import fifo_out_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            reset,
  input wire logic                            ce,
  input wire logic                            hsel,
  input wire logic [1:0]                      htrans,
  input wire logic                            hready,
  input wire logic                            hreadyout,
  input wire logic                            hresp,
  input wire logic                            readerStrobe,
  input wire logic [fifo_out_pkg::DATA_W-1:0] readerData,
  input wire logic                            dataAvail
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire take = hsel && hready && hreadyout && ce && htrans == HTRANS_NONSEQ;
  //////////////////////////////////////////////////////////////////////////
  AST_TAKE_WAIT: assert property (take |=> !hreadyout)
    else $error("request taken without a wait state");
  AST_ONE_WAIT: assert property (!hreadyout && ce |=> hreadyout)
    else $error("wait state longer than one cycle");
  AST_RESP_OKAY: assert property (hresp == HRESP_OKAY)
    else $error("error response seen");
  AST_RESET_CLEAR: assert property ($fell(reset) |-> !dataAvail)
    else $error("data flag set after reset");
  AST_AVAIL_DROP: assert property ($changed(readerData) |=> !dataAvail)
    else $error("data flag kept after a word left");
  AST_NEED_STROBE: assert property ($changed(readerData) |->
    $past(readerStrobe, 2) || $past(readerStrobe, 3))
    else $error("word moved without a strobe");
  AST_NEED_AVAIL: assert property ($changed(readerData) |->
    $past(dataAvail))
    else $error("word moved while no data flagged");
  // Pins pass two flops, so an output can not react at once
  AST_SYNC_DELAY: assert property ($rose(readerStrobe) |=>
    $stable(readerData))
    else $error("strobe used before synchronising");
  cover property ($changed(readerData));
  cover property ($rose(dataAvail));
  cover property (take);
endmodule // fifo_async_output_stage_checker

bind fifo_async_output_stage fifo_async_output_stage_checker chk (
  .clk(clk), .reset(reset), .ce(ce), .hsel(hsel), .htrans(htrans),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .readerStrobe(readerStrobe), .readerData(readerData),
  .dataAvail(dataAvail));

// ### fifo_async_output_stage_bench.sv
// Self-checking bench for the FIFO output stage and its reader
`timescale 1ns/1ps
module fifo_async_output_stage_bench;
  import fifo_out_pkg::*;
  logic        clk = 1'h0;
  logic        reset = 1'h1;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        readerClk;
  logic        readerStrobe;
  logic [7:0]  readerData;
  logic        dataAvail;
  logic        want = 1'h0;
  logic        oneShot = 1'h1;
  logic [31:0] q;
  time         last;
  int          mismatches = 0;
  int          checks_done = 0;
  logic [7:0]  words [6] = '{8'hA1, 8'hB2, 8'hC3, 8'h11, 8'h22, 8'h33};

  fifo_async_output_stage dut (
    .clk(clk), .reset(reset), .ce(1'h1), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .readerClk(readerClk), .readerStrobe(readerStrobe),
    .readerData(readerData), .dataAvail(dataAvail));
  reader_model reader (
    .want(want), .oneShot(oneShot), .dataAvail(dataAvail),
    .readerClk(readerClk), .readerStrobe(readerStrobe));

  always #4 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, exp, input string m);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Values read at the rising edge are those the slave presents before it
  task automatic waitReady(output logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'h1 && n < 100);
    d = hrdata;
    if (hreadyout !== 1'h1) begin
      mismatches++;
      $display("BAD %0t bus answer timed out", $time);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    waitReady(r);
    htrans <= 2'h0;
    hwdata <= d;
    waitReady(r);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0, q);
    check(q, e, "register read");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'h1, a, d, q);
  endtask
  task automatic waitAvail();
    int n;
    n = 0;
    while (dataAvail !== 1'h1 && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (dataAvail !== 1'h1) begin
      mismatches++;
      $display("BAD %0t data flag timed out", $time);
    end
    @(posedge clk);
  endtask
  task automatic pull(input logic [7:0] e, input logic g);
    int n;
    n = 0;
    while (readerData !== e && n < 300) begin
      @(negedge clk);
      n++;
    end
    check({24'h0, readerData}, {24'h0, e}, "word out");
    if (g === 1'h1) check(32'($time - last), 32'h40, "gap");
    last = $time;
    @(posedge clk);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(OFFS_STATUS, 32'h10);
    rd(OFFS_CTRL, 32'h0);
    wr(8'h40, 32'hFFFFFFFF);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 3; i++) wr(OFFS_PUSH, {24'h0, words[i]});
    waitAvail();
    rd(OFFS_STATUS, 32'h19);
    want <= 1'h1;
    for (int i = 0; i < 3; i++) pull(words[i], 1'h0);
    want <= 1'h0;
    // Let the last pop finish before looking at the flags
    repeat (4) @(posedge clk);
    rd(OFFS_STATUS, 32'h14);
    rd(OFFS_HOLD, 32'hC3);
    wr(OFFS_PUSH, {24'h0, words[3]});
    waitAvail();
    rd(OFFS_STATUS, 32'h19);
    wr(OFFS_CTRL, 32'h1);
    rd(OFFS_CTRL, 32'h1);
    for (int i = 4; i < 6; i++) wr(OFFS_PUSH, {24'h0, words[i]});
    oneShot <= 1'h0;
    want <= 1'h1;
    for (int i = 3; i < 6; i++) pull(words[i], i > 3);
    want <= 1'h0;
    wr(OFFS_PUSH, 32'h5A);
    reset <= 1'h1;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    rd(OFFS_STATUS, 32'h10);
    rd(OFFS_CTRL, 32'h0);
    final_report();
  end

  initial begin
    #200000;
    mismatches++;
    final_report();
  end
endmodule // fifo_async_output_stage_bench
